// [pkg/muldiv_pkg.sv]
// Summary of operation
// - unsigned multiply, divide, normalize and shift only
// - 32/16 divide gives 32q 16r after 17
// - 16/16 divide gives 16q 16r after 9
// - 16x16 multiply gives 32-bit product after 10
// - normalize 3-34, shift 4-34 cycles from last write
// - software waits fixed cycles, no done flag
// - control bits: error 7, overflow 6, direction 5, count 4:0
// - early operand write sets error; control read clears
// - error tracking spans first byte0 write to last read
// - zero divisor sets overflow flag
// - product above 0x0000FFFF sets overflow flag
// - normalizing operand with msb set sets overflow
// - zero count normalizes, nonzero count shifts that many
// - normalize shifts left, writes back, stores shift count
// - load bytes 0-3, control write starts shift
// - byte0 write restarts write sequence, last write starts divide
// - dividend lsb first bytes 0-3, divisor bytes 4-5
// - quotient bytes 0-3, remainder 4-5; last read frees
// - multiply writes bytes 0,4,1,5 in that order
// - product lsb first in bytes 0-3
// - load bytes 0-3, control write with zero count
package muldiv_pkg;
    localparam logic [7:0] OPERAND_BYTE_0_ADDR = 8'hF9;
    localparam logic [7:0] OPERAND_BYTE_1_ADDR = 8'hFA;
    localparam logic [7:0] OPERAND_BYTE_2_ADDR = 8'hFB;
    localparam logic [7:0] OPERAND_BYTE_3_ADDR = 8'hFC;
    localparam logic [7:0] OPERAND_BYTE_4_ADDR = 8'hFD;
    localparam logic [7:0] OPERAND_BYTE_5_ADDR = 8'hFE;
    localparam logic [7:0] ARITH_CONTROL_FLAGS_ADDR = 8'hFF;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int ERROR_BIT = 7;
    localparam int OVERFLOW_BIT = 6;
    localparam int DIRECTION_BIT = 5;
    localparam int COUNT_MSB = 4;
    localparam int DIV32_CYCLES = 17;
    localparam int DIV16_CYCLES = 9;
    localparam int MUL_CYCLES = 10;
    localparam int SHIFT_BASE_CYCLES = 2;
    // apb side register map, word aligned
    localparam logic [11:0] APB_CMD_ADDR = 12'h000;
    localparam logic [11:0] APB_WDATA_ADDR = 12'h004;
    localparam logic [11:0] APB_RDATA_ADDR = 12'h008;
    localparam logic [11:0] APB_STATUS_ADDR = 12'h00C;
    localparam int CMD_WRITE_BIT = 8;
    localparam int CMD_READ_BIT = 9;
    typedef enum logic [2:0] {OP_NONE, OP_DIV32, OP_DIV16, OP_MUL, OP_NORM, OP_SHIFT} op_t;
endpackage : muldiv_pkg

// [pkg/sfr_if.sv]
`timescale 1ns/1ps
interface sfr_if;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport device (input addr, input wr, input rd, input wdata, output rdata);
    modport cpu (output addr, output wr, output rd, output wdata, input rdata);
endinterface : sfr_if

// [src/muldiv_core.sv]
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module muldiv_core (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // job
    input wire logic start,
    input wire muldiv_pkg::op_t op,
    input wire logic [31:0] opa,
    input wire logic [15:0] opb,
    input wire logic [4:0] count_in,
    input wire logic dir_right,
    // result
    output logic done,
    output logic [31:0] res_a,
    output logic [15:0] res_b,
    output logic [4:0] count_out,
    output logic ovf
);
    // one-cycle divider and multiplier at start; the counter only paces the result
    logic [31:0] a_q;
    logic [15:0] b_q;
    logic [16:0] rem_q;
    logic [5:0] cnt_q;
    logic [4:0] sh_q;
    logic busy_q;
    muldiv_pkg::op_t op_q;
    logic dir_q;
    logic [4:0] shamt_q;
    logic [31:0] prod;
    // wide divider traded for area: latency stays fixed whatever the operands
    wire logic div_zero = opb == 16'h0000;
    wire logic [31:0] dividend = (op == muldiv_pkg::OP_DIV16) ? {16'h0000, opa[15:0]} : opa;
    wire logic [31:0] quot = div_zero ? 32'h00000000 : dividend / {16'h0000, opb};
    wire logic [31:0] rmd = div_zero ? 32'h00000000 : dividend % {16'h0000, opb};
    assign prod = opa[15:0] * opb;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= 32'h00000000;
            b_q <= 16'h0000;
            rem_q <= 17'h00000;
            cnt_q <= 6'h00;
            sh_q <= 5'h00;
            busy_q <= 1'b0;
            op_q <= muldiv_pkg::OP_NONE;
            dir_q <= 1'b0;
            shamt_q <= 5'h00;
            done <= 1'b0;
            res_a <= 32'h00000000;
            res_b <= 16'h0000;
            count_out <= 5'h00;
            ovf <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy_q <= 1'b1;
                op_q <= op;
                b_q <= opb;
                rem_q <= {1'b0, rmd[15:0]};
                sh_q <= 5'h00;
                ovf <= 1'b0;
                case (op)
                    muldiv_pkg::OP_DIV32: begin
                        a_q <= quot;
                        cnt_q <= 6'(muldiv_pkg::DIV32_CYCLES - 1);
                    end
                    muldiv_pkg::OP_DIV16: begin
                        a_q <= quot;
                        cnt_q <= 6'(muldiv_pkg::DIV16_CYCLES - 1);
                    end
                    muldiv_pkg::OP_MUL: begin
                        a_q <= prod;
                        cnt_q <= 6'(muldiv_pkg::MUL_CYCLES - 1);
                    end
                    muldiv_pkg::OP_NORM: begin
                        a_q <= opa;
                        cnt_q <= 6'(muldiv_pkg::SHIFT_BASE_CYCLES);
                    end
                    default: begin
                        // direction and count latched: the bus byte may change mid-shift
                        a_q <= opa;
                        cnt_q <= 6'(muldiv_pkg::SHIFT_BASE_CYCLES);
                        sh_q <= count_in;
                        dir_q <= dir_right;
                        shamt_q <= count_in;
                    end
                endcase
            end else if (busy_q) begin
                case (op_q)
                    muldiv_pkg::OP_NORM: begin
                        if (cnt_q == 6'h01 && a_q[31] == 1'b0 && a_q != 32'h00000000
                            && sh_q != 5'h1F) begin
                            a_q <= {a_q[30:0], 1'b0};
                            sh_q <= sh_q + 5'h01;
                            cnt_q <= cnt_q;
                        end
                    end
                    muldiv_pkg::OP_SHIFT: begin
                        if (cnt_q == 6'h01 && sh_q != 5'h00) begin
                            a_q <= dir_q ? {1'b0, a_q[31:1]} : {a_q[30:0], 1'b0};
                            sh_q <= sh_q - 5'h01;
                            cnt_q <= cnt_q;
                        end
                    end
                    default: begin
                    end
                endcase
                if (!(cnt_q == 6'h01 && ((op_q == muldiv_pkg::OP_NORM && a_q[31] == 1'b0
                      && a_q != 32'h00000000 && sh_q != 5'h1F)
                      || (op_q == muldiv_pkg::OP_SHIFT && sh_q != 5'h00)))) begin
                    cnt_q <= cnt_q - 6'h01;
                end
                if (cnt_q == 6'h00) begin
                    busy_q <= 1'b0;
                end
                if (cnt_q == 6'h01 && !((op_q == muldiv_pkg::OP_NORM && a_q[31] == 1'b0
                      && a_q != 32'h00000000 && sh_q != 5'h1F)
                      || (op_q == muldiv_pkg::OP_SHIFT && sh_q != 5'h00))) begin
                    busy_q <= 1'b0;
                    done <= 1'b1;
                    res_b <= rem_q[15:0];
                    count_out <= (op_q == muldiv_pkg::OP_SHIFT) ? shamt_q : sh_q;
                    if (op_q == muldiv_pkg::OP_DIV16) begin
                        res_a <= {16'h0000, a_q[15:0]};
                    end else begin
                        res_a <= a_q;
                    end
                    if (op_q == muldiv_pkg::OP_DIV32 || op_q == muldiv_pkg::OP_DIV16) begin
                        ovf <= (b_q == 16'h0000);
                    end else if (op_q == muldiv_pkg::OP_MUL) begin
                        ovf <= (a_q > 32'h0000FFFF);
                    end else begin
                        ovf <= 1'b0;
                    end
                end
            end
        end
    end
endmodule : muldiv_core

// [src/muldiv_unit.sv]
`timescale 1ns/1ps
module muldiv_unit (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // special-function register port
    sfr_if.device sfr
);
    logic [7:0] md_q [0:5];
    logic [7:0] ctl_q;
    logic busy_q;
    logic track_q;
    logic [2:0] wseq_q;
    logic [2:0] rlast_q;
    logic start;
    muldiv_pkg::op_t op;
    logic done;
    logic [31:0] res_a;
    logic [15:0] res_b;
    logic [4:0] count_out;
    logic ovf;
    logic [7:0] rdata_q;

    wire logic [2:0] idx = 3'(sfr.addr - muldiv_pkg::OPERAND_BYTE_0_ADDR);
    wire logic is_md = sfr.addr >= muldiv_pkg::OPERAND_BYTE_0_ADDR
        && sfr.addr <= muldiv_pkg::OPERAND_BYTE_5_ADDR;
    wire logic is_ctl = sfr.addr == muldiv_pkg::ARITH_CONTROL_FLAGS_ADDR;
    wire logic md_wr = sfr.wr && is_md;
    wire logic ctl_wr = sfr.wr && is_ctl;
    // sequence state: 1 byte0, 2 byte1 next, 3 byte4 next (multiply), 4 byte2/3 seen
    wire logic wr5 = md_wr && idx == 3'd5;
    // byte5 lands on the start edge itself, so the core takes it from the bus
    wire logic [15:0] divisor_now = {wr5 ? sfr.wdata : md_q[5], md_q[4]};
    wire logic is_mul = wseq_q == 3'd3;
    assign start = (wr5 || ctl_wr) && !busy_q;
    assign op = ctl_wr ? ((sfr.wdata[4:0] == 5'h00) ? muldiv_pkg::OP_NORM
                                                 : muldiv_pkg::OP_SHIFT)
              : is_mul ? muldiv_pkg::OP_MUL
              : (wseq_q == 3'd4) ? muldiv_pkg::OP_DIV32 : muldiv_pkg::OP_DIV16;
    wire logic norm_ovf = ctl_wr && sfr.wdata[4:0] == 5'h00 && md_q[3][7];

    muldiv_core u_core (
        .pclk(pclk),
        .presetn(presetn),
        .start(start),
        .op(op),
        .opa({md_q[3], md_q[2], md_q[1], md_q[0]}),
        .opb(divisor_now),
        .count_in(sfr.wdata[4:0]),
        .dir_right(sfr.wdata[muldiv_pkg::DIRECTION_BIT]),
        .done(done),
        .res_a(res_a),
        .res_b(res_b),
        .count_out(count_out),
        .ovf(ovf)
    );

    assign sfr.rdata = rdata_q;
    wire logic [7:0] rsel = is_ctl ? ctl_q : is_md ? md_q[idx] : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 6; i++) begin
                md_q[i] <= muldiv_pkg::REG_RESET;
            end
            ctl_q <= muldiv_pkg::REG_RESET;
            busy_q <= 1'b0;
            track_q <= 1'b0;
            wseq_q <= 3'd0;
            rlast_q <= 3'd0;
            rdata_q <= 8'h00;
        end else begin
            if (sfr.rd) begin
                rdata_q <= rsel;
            end
            if (md_wr && !busy_q) begin
                md_q[idx] <= sfr.wdata;
            end
            // operand byte order bookkeeping
            if (md_wr && idx == 3'd0) begin
                wseq_q <= 3'd1;
                track_q <= 1'b1;
            end else if (md_wr && idx == 3'd1 && wseq_q == 3'd1) begin
                wseq_q <= 3'd2;
            end else if (md_wr && idx == 3'd4 && wseq_q == 3'd1) begin
                wseq_q <= 3'd3;
            end else if (md_wr && (idx == 3'd2 || idx == 3'd3)) begin
                wseq_q <= 3'd4;
            end
            if (start) begin
                busy_q <= 1'b1;
                rlast_q <= (op == muldiv_pkg::OP_DIV32 || op == muldiv_pkg::OP_DIV16)
                    ? 3'd5 : 3'd3;
            end
            if (done) begin
                busy_q <= 1'b0;
                md_q[0] <= res_a[7:0];
                md_q[1] <= res_a[15:8];
                md_q[2] <= res_a[23:16];
                md_q[3] <= res_a[31:24];
                if (rlast_q == 3'd5) begin
                    md_q[4] <= res_b[7:0];
                    md_q[5] <= res_b[15:8];
                end
                ctl_q[4:0] <= count_out;
            end
            if (ctl_wr && !busy_q) begin
                ctl_q[5:0] <= sfr.wdata[5:0];
            end
            // overflow: set wins over the clear of a new start
            if (done) begin
                ctl_q[muldiv_pkg::OVERFLOW_BIT] <= ovf || ctl_q[muldiv_pkg::OVERFLOW_BIT];
            end else if (norm_ovf && !busy_q) begin
                ctl_q[muldiv_pkg::OVERFLOW_BIT] <= 1'b1;
            end else if (start) begin
                ctl_q[muldiv_pkg::OVERFLOW_BIT] <= 1'b0;
            end
            // error: set wins over read clear
            if ((md_wr || ctl_wr) && busy_q) begin
                ctl_q[muldiv_pkg::ERROR_BIT] <= 1'b1;
            end else if (sfr.rd && is_ctl) begin
                ctl_q[muldiv_pkg::ERROR_BIT] <= 1'b0;
            end else if (sfr.rd && is_md && track_q && !busy_q && idx == rlast_q) begin
                ctl_q[muldiv_pkg::ERROR_BIT] <= 1'b0;
                track_q <= 1'b0;
            end
        end
    end
endmodule : muldiv_unit

// [src/muldiv_host.sv]
`timescale 1ns/1ps
module muldiv_host (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // special-function register port
    sfr_if.cpu sfr
);
    // software issues byte accesses in documented order and waits itself (no done flag)
    logic [7:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic wr_q;
    logic rd_q;
    logic rd_wait_q;
    logic rvalid_q;
    logic [31:0] rsel;
    wire logic acc = psel && penable;
    wire logic cmd_wr = acc && pwrite && paddr == muldiv_pkg::APB_CMD_ADDR;
    assign sfr.addr = addr_q;
    assign sfr.wr = wr_q;
    assign sfr.rd = rd_q;
    assign sfr.wdata = wdata_q;
    assign pready = 1'b1;
    assign pslverr = acc && paddr != muldiv_pkg::APB_CMD_ADDR
        && paddr != muldiv_pkg::APB_WDATA_ADDR && paddr != muldiv_pkg::APB_RDATA_ADDR
        && paddr != muldiv_pkg::APB_STATUS_ADDR;
    // read word captured in the setup cycle so prdata comes from a flop
    always_comb begin
        case (paddr)
            muldiv_pkg::APB_CMD_ADDR: rsel = {24'h000000, addr_q};
            muldiv_pkg::APB_WDATA_ADDR: rsel = {24'h000000, wdata_q};
            muldiv_pkg::APB_RDATA_ADDR: rsel = {24'h000000, rdata_q};
            muldiv_pkg::APB_STATUS_ADDR: rsel = {31'h00000000, rvalid_q};
            default: rsel = 32'h00000000;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= 8'h00;
            wdata_q <= 8'h00;
            rdata_q <= 8'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            rd_wait_q <= 1'b0;
            rvalid_q <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            if (psel && !penable) begin
                prdata <= rsel;
            end
            wr_q <= cmd_wr && pwdata[muldiv_pkg::CMD_WRITE_BIT];
            rd_q <= cmd_wr && pwdata[muldiv_pkg::CMD_READ_BIT];
            rd_wait_q <= rd_q;
            if (cmd_wr) begin
                addr_q <= pwdata[7:0];
                rvalid_q <= 1'b0;
            end
            if (acc && pwrite && paddr == muldiv_pkg::APB_WDATA_ADDR) begin
                wdata_q <= pwdata[7:0];
            end
            if (rd_wait_q) begin
                rdata_q <= sfr.rdata;
                rvalid_q <= 1'b1;
            end
        end
    end
endmodule : muldiv_host

// [sim/muldiv_unit_chk.sv]
`timescale 1ns/1ps
module muldiv_unit_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // special-function register port
    input wire logic [7:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    logic rd_q;
    logic [7:0] raddr_q;
    logic [7:0] prev_q;
    logic [4:0] since_b5_q;
    logic pristine_q, err_exp_q, clean_q, norm_ov_q, dz_q, b3_msb_q, b4_zero_q;
    wire op_wr = wr && addr >= muldiv_pkg::OPERAND_BYTE_0_ADDR
        && addr <= muldiv_pkg::OPERAND_BYTE_5_ADDR;
    wire ctrl_rd = rd_q && raddr_q == muldiv_pkg::ARITH_CONTROL_FLAGS_ADDR;
    wire b5_wr = wr && addr == muldiv_pkg::OPERAND_BYTE_5_ADDR;
    wire ctl_wr = wr && addr == muldiv_pkg::ARITH_CONTROL_FLAGS_ADDR;
    wire b0_wr = wr && addr == muldiv_pkg::OPERAND_BYTE_0_ADDR;
    // window of 10 cycles after a byte5 write: the divide or multiply it starts is taken to last that long
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_q <= 1'b0;
            raddr_q <= 8'h00;
            prev_q <= 8'h00;
            since_b5_q <= 5'h1F;
            pristine_q <= 1'b1;
            err_exp_q <= 1'b0;
            clean_q <= 1'b0;
            norm_ov_q <= 1'b0;
            dz_q <= 1'b0;
            b3_msb_q <= 1'b0;
            b4_zero_q <= 1'b0;
        end else begin
            rd_q <= rd;
            raddr_q <= addr;
            if (wr) prev_q <= addr;
            if (wr) pristine_q <= 1'b0;
            if (b5_wr) since_b5_q <= 5'h00;
            else if (since_b5_q != 5'h1F) since_b5_q <= since_b5_q + 5'h01;
            if (op_wr && since_b5_q < 5'h0A) err_exp_q <= 1'b1;
            else if (rd_q) err_exp_q <= 1'b0;
            if (wr) clean_q <= 1'b0;
            else if (ctrl_rd) clean_q <= 1'b1;
            if (wr && addr == muldiv_pkg::OPERAND_BYTE_3_ADDR) b3_msb_q <= wdata[7];
            if (wr && addr == muldiv_pkg::OPERAND_BYTE_4_ADDR) b4_zero_q <= wdata == 8'h00;
            if (ctl_wr) norm_ov_q <= wdata[4:0] == 5'h00 && b3_msb_q;
            else if (b0_wr) norm_ov_q <= 1'b0;
            if (b5_wr) dz_q <= prev_q == muldiv_pkg::OPERAND_BYTE_4_ADDR
                && wdata == 8'h00 && b4_zero_q;
            else if (b0_wr || ctl_wr) dz_q <= 1'b0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_reset_zero: assert property (rd_q && pristine_q |-> rdata == 8'h00)
        else $error("register not zero after reset");
    chk_err_set: assert property (ctrl_rd && err_exp_q |-> rdata[7])
        else $error("early operand write left error flag clear");
    chk_err_clear: assert property (ctrl_rd && clean_q |-> !rdata[7])
        else $error("error flag survived control read");
    chk_norm_ovf: assert property (ctrl_rd && norm_ov_q |-> rdata[6])
        else $error("normalized operand without overflow");
    chk_norm_count: assert property (ctrl_rd && norm_ov_q |-> rdata[5:0] == 6'h00)
        else $error("shift count nonzero for normalized operand");
    chk_div_zero: assert property (ctrl_rd && dz_q && since_b5_q > 5'h13 |-> rdata[6])
        else $error("zero divisor without overflow");
    chk_wr_single: assert property (wr |=> !wr)
        else $error("write strobe longer than one cycle");
    chk_rd_single: assert property (rd |=> !rd && !wr)
        else $error("read strobe longer than one cycle");
    cov_err: cover property (ctrl_rd && err_exp_q);
    cov_dz: cover property (ctrl_rd && dz_q);
    cov_norm: cover property (ctrl_rd && norm_ov_q);
endmodule : muldiv_unit_chk

// [sim/test_muldiv_accelerator.sv]
`timescale 1ns/1ps
module test_muldiv_accelerator;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    int err_count = 0;
    int n_tests = 0;
    integer seed = 32'hB40D06D0;
    always #5 pclk = ~pclk;
    sfr_if sfr_if_i ();
    muldiv_unit muldiv_unit_i (.pclk(pclk), .presetn(presetn), .sfr(sfr_if_i));
    muldiv_host muldiv_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sfr(sfr_if_i));
    muldiv_unit_chk muldiv_unit_chk_i (.pclk(pclk), .presetn(presetn), .addr(sfr_if_i.addr),
        .wr(sfr_if_i.wr), .rd(sfr_if_i.rd), .wdata(sfr_if_i.wdata), .rdata(sfr_if_i.rdata));
    task print_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    // idle edge after release: keeps psel from being assigned twice in one step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task w(input int i, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, muldiv_pkg::APB_WDATA_ADDR, {24'h0, d}, q, e);
        apb(1'b1, muldiv_pkg::APB_CMD_ADDR, 32'h100 | (muldiv_pkg::OPERAND_BYTE_0_ADDR + i), q, e);
    endtask : w
    task r(input int i, output logic [7:0] d);
        logic [31:0] q;
        logic e;
        int n;
        apb(1'b1, muldiv_pkg::APB_CMD_ADDR, 32'h200 | (muldiv_pkg::OPERAND_BYTE_0_ADDR + i), q, e);
        n = 0;
        // first poll still sees the flag the command write cleared; the byte lands a cycle later
        do begin
            apb(1'b0, muldiv_pkg::APB_STATUS_ADDR, 32'h0, q, e);
            n++;
        end while ((n < 2 || q[0] !== 1'b1) && n < 20);
        chk("read valid", q[0], 1'b1);
        apb(1'b0, muldiv_pkg::APB_RDATA_ADDR, 32'h0, q, e);
        d = q[7:0];
    endtask : r
    function automatic logic [55:0] expect_op(input int k, input logic [31:0] a,
        input logic [15:0] b, input logic [5:0] c);
        logic [31:0] q;
        logic [15:0] m;
        logic ov;
        logic [4:0] lz;
        q = 0; m = 0; ov = 0; lz = 0;
        case (k)
            0: if (b == 0) ov = 1; else begin q = a / b; m = a % b; end
            1: if (b == 0) ov = 1; else begin q = a[15:0] / b; m = a[15:0] % b; end
            2: begin q = a[15:0] * b; ov = q > 32'h0000FFFF; end
            3: begin
                q = a; ov = a[31];
                while (!q[31]) begin q = q << 1; lz = lz + 5'h01; end
            end
            default: q = c[5] ? a >> c[4:0] : a << c[4:0];
        endcase
        return {1'b0, ov, 1'b0, lz, m, q};
    endfunction : expect_op
    // kinds: 0 div32, 1 div16, 2 mul, 3 normalize, 4 shift
    task automatic op(input int k, input logic [31:0] a, input logic [15:0] b, input logic [5:0] c);
        logic [55:0] src, ex;
        logic [23:0] wl, rl;
        logic [7:0] d, mk;
        int wn, rn, i;
        src = {2'b00, c, b, a};
        ex = expect_op(k, a, b, c);
        wl = (k == 0) ? 24'h012345 : (k == 1) ? 24'h0145 : (k == 2) ? 24'h0415 : 24'h01236;
        wn = (k == 0) ? 6 : (k > 2) ? 5 : 4;
        rl = (k == 0) ? 24'h012345 : (k == 1) ? 24'h0145 : 24'h0123;
        rn = (k == 0) ? 6 : 4;
        mk = (k == 3) ? 8'hFF : 8'hC0;
        for (int j = 0; j < wn; j++) begin
            i = (wl >> (4 * (wn - 1 - j))) & 15;
            w(i, src[8*i+:8]);
        end
        repeat (40) @(posedge pclk);
        for (int j = 0; j < rn; j++) begin
            i = (rl >> (4 * (rn - 1 - j))) & 15;
            r(i, d);
            if (!(k < 2 && b == 0)) chk("result byte", d, ex[8*i+:8]);
        end
        r(6, d);
        chk("control flags", d & mk, ex[55:48] & mk);
        $display("test op %0d done", k);
    endtask : op
    initial begin
        repeat (60000) @(posedge pclk);
        $display("watchdog expired");
        err_count++;
        print_verdict();
    end
    initial begin
        logic [31:0] a, q;
        logic [15:0] b;
        logic [5:0] c;
        logic [7:0] d;
        logic e;
        int k;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) begin
            r(i, d);
            chk("reset value", d, 8'h00);
        end
        apb(1'b0, 12'h010, 32'h0, q, e);
        chk("unmapped slverr", e, 1'b1);
        $display("test reset done");
        op(0, 32'h12345678, 16'h0000, 6'h00);
        op(0, 32'hFFFFFFFF, 16'h0001, 6'h00);
        op(1, 32'h0000ABCD, 16'h0000, 6'h00);
        op(2, 32'h0000FFFF, 16'hFFFF, 6'h00);
        op(2, 32'h000000FF, 16'h0100, 6'h00);
        op(3, 32'h80000001, 16'h0000, 6'h00);
        op(3, 32'h00000001, 16'h0000, 6'h00);
        op(4, 32'h80000001, 16'h0000, 6'h1F);
        op(4, 32'h80000001, 16'h0000, 6'h21);
        for (int n = 0; n < 25; n++) begin
            k = n % 5;
            a = $random(seed);
            b = $random(seed);
            c = $random(seed);
            if (k == 3) a = a | 32'h1;
            if (k < 4) c = 6'h00;
            else if (c[4:0] == 5'h00) c[0] = 1'b1;
            op(k, a, b, c);
        end
        // operand write during a running divide
        for (int i = 0; i < 6; i++) w(i, 8'h11 + i);
        w(0, 8'h55);
        r(6, d);
        chk("error flag set", d[7], 1'b1);
        r(6, d);
        chk("error flag cleared", d[7], 1'b0);
        repeat (40) @(posedge pclk);
        $display("test error done");
        op(2, 32'h00001234, 16'h0056, 6'h00);
        print_verdict();
    end
endmodule : test_muldiv_accelerator
